/* core/soft_power_consts.svh */
`ifndef SOFT_POWER_CONSTS_SVH
`define SOFT_POWER_CONSTS_SVH

// Register indices on the configuration index/data port
`define SPW_WAKE_ENABLE_ONE   8'hB0
`define SPW_WAKE_ENABLE_TWO   8'hB1
`define SPW_WAKE_STATUS_ONE   8'hB2
`define SPW_WAKE_STATUS_TWO   8'hB3
`define SPW_SECOND_DELAY      8'hB8
`define SPW_WATCHDOG_CONTROL  8'hF4

// Field positions
`define SPW_OFF_ENABLE_BIT    7
`define SPW_SOFT_OFF_BIT      7
`define SPW_RESTART_BIT       6
`define SPW_STOP_BIT          5

// Reset values
`define SPW_WAKE_ENABLE_ONE_RST 8'h00
`define SPW_WAKE_ENABLE_TWO_RST 8'h80
`define SPW_SECOND_DELAY_RST    8'h00
`define SPW_DELAY_MAX_CODE      8'h3F

// Timing
`define SPW_CLOCK_HZ          125000000
`define SPW_SLOW_HZ           32768
`define SPW_STEP_MS           500
`define SPW_OVERRIDE_MS       4000

`endif

/* core/soft_power_pkg.sv */
package soft_power_pkg;

  // Where the SCI output is steered
  typedef enum logic [1:0] {
    SCI_TO_PME_PIN = 2'b00,
    SCI_TO_IRQ11   = 2'b01,
    SCI_TO_SERIRQ  = 2'b10,
    SCI_TO_NONE    = 2'b11
  } sci_route_type;

  // Power state of the main supply request
  typedef enum logic {
    POWER_OFF = 1'b0,
    POWER_ON  = 1'b1
  } power_state_type;

endpackage

/* core/soft_power_acpi_events.sv */
// Contract
// - Wake status always set; enabled wakes power on
// - Button power-off enable defaults to one
// - Control bits 7:5: soft off, restart, stop
// - Second delay 500 ms to 32 s, default 500 ms
// - Button held over four seconds forces off
// - Override works only while its enable set
// - Override sets own status, clears button status
// - Override status clears only on write one
// - Override timer counts while held, clears released
// - Timer from divided 32 kHz, fires 4-4.5 s
// - Timer expiry clears the power state flop
// - Power state held across trickle supply loss
// - Alarm remember brings power state on
// - Trickle reset off brings power state off
// - Configuration reset only on battery reset
// - SCI and SMI route enables, either or both
// - Events go to SMI and SCI when routed
// - SCI to shared pin, IRQ11 or serial IRQ
// - SCI polarity and drive type selectable on shared pin only
// - Alarm sets PME status, PME when enabled
// - GPE SCI enable turns PME events into SCI
// - Device and SMI-to-PME enables: SMI gives SCI
// - Button status and enable raise SCI
// - Button fall or enabled wake powers on
// - Control write with bit 7 powers off
`timescale 1ns/1ns
`include "soft_power_consts.svh"

module soft_power_acpi_events #(
  parameter int WAKE_COUNT     = 15,
  parameter int SLOW_PER_STEP  = `SPW_SLOW_HZ * `SPW_STEP_MS / 1000
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  trickle_por,
  input  wire logic                  trickle_only,
  input  wire logic                  button_in,
  input  wire logic [WAKE_COUNT-1:0] wake_events,
  input  wire logic                  alarm_event,
  input  wire logic                  alarm_while_absent,
  input  wire logic                  alarm_remember_enable,
  input  wire logic                  trickle_reset_off,
  input  wire logic [7:0]            reg_index,
  input  wire logic                  reg_write,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  sci_route_enable,
  input  wire logic                  smi_route_enable,
  input  wire logic                  override_enable,
  input  wire logic                  override_status_clear,
  input  wire logic                  button_enable,
  input  wire logic                  button_status_clear,
  input  wire logic                  alarm_sci_enable,
  input  wire logic                  alarm_sci_status_clear,
  input  wire logic                  alarm_pme_enable,
  input  wire logic                  alarm_pme_status_clear,
  input  wire logic                  gpe_sci_enable,
  input  wire logic                  device_interrupt_pme_enable,
  input  wire logic                  smi_to_pme_enable,
  input  wire logic                  smi_event_any,
  input  wire logic [1:0]            sci_route_select,
  input  wire logic                  sci_active_high,
  input  wire logic                  sci_push_pull,
  output logic [7:0]                 reg_rdata,
  output logic                       power_on_request_n,
  output logic                       override_status,
  output logic                       button_status,
  output logic                       alarm_sci_status,
  output logic                       alarm_pme_status,
  output logic                       smi_out,
  output logic                       irq11_out,
  output logic                       serirq_sci,
  output logic                       pme_sci_pin_out,
  output logic                       pme_sci_pin_oe
);

  // ****************************************************************
  // Constants and checks
  // ****************************************************************
  localparam int SLOW_DIV       = `SPW_CLOCK_HZ / `SPW_SLOW_HZ;
  localparam int OVERRIDE_STEPS = `SPW_OVERRIDE_MS / `SPW_STEP_MS;
  localparam int NSYNC          = WAKE_COUNT + 3;

  generate
    if (WAKE_COUNT < 1 || WAKE_COUNT > 15 || SLOW_PER_STEP < 1)
      $error("soft_power_acpi_events: unsupported parameters");
  endgenerate

  // Status bit: hardware set wins over software clear
  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    w1c = set | (cur & ~clr);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;
  logic [NSYNC-1:0] raw_pins;

  assign raw_pins = {trickle_por, alarm_event, button_in, wake_events};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      // Two stages, then a third for edge detection
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
          sync_c[g] <= 1'b0;
        end else begin
          sync_a[g] <= raw_pins[g];
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
        end
      end
    end
  endgenerate

  logic [WAKE_COUNT-1:0] wake_rise;
  logic                  button_fall;
  logic                  button_rise;
  logic                  alarm_rise;
  logic                  por_rise;

  assign wake_rise   = sync_b[WAKE_COUNT-1:0] & ~sync_c[WAKE_COUNT-1:0];
  assign button_rise = sync_b[WAKE_COUNT] & ~sync_c[WAKE_COUNT];
  assign button_fall = ~sync_b[WAKE_COUNT] & sync_c[WAKE_COUNT];
  assign alarm_rise  = sync_b[WAKE_COUNT+1] & ~sync_c[WAKE_COUNT+1];
  assign por_rise    = sync_b[WAKE_COUNT+2] & ~sync_c[WAKE_COUNT+2];

  // ****************************************************************
  // Configuration registers (battery reset only)
  // ****************************************************************
  logic [7:0] wake_enable_one;
  logic [7:0] wake_enable_two;
  logic [7:0] wake_status_one;
  logic [7:0] wake_status_two;
  logic [7:0] second_delay_setting;
  logic       counter_restart;
  logic       counter_stop;
  logic       soft_power_off_cmd;
  logic       wr_en1;
  logic       wr_en2;
  logic       wr_st1;
  logic       wr_st2;
  logic       wr_dly;
  logic       wr_ctl;
  logic [15:0] wake_rise_all;
  logic [15:0] wake_en_all;

  assign wr_en1 = reg_write && reg_index == `SPW_WAKE_ENABLE_ONE;
  assign wr_en2 = reg_write && reg_index == `SPW_WAKE_ENABLE_TWO;
  assign wr_st1 = reg_write && reg_index == `SPW_WAKE_STATUS_ONE;
  assign wr_st2 = reg_write && reg_index == `SPW_WAKE_STATUS_TWO;
  assign wr_dly = reg_write && reg_index == `SPW_SECOND_DELAY;
  assign wr_ctl = reg_write && reg_index == `SPW_WATCHDOG_CONTROL;

  assign wake_rise_all = 16'(wake_rise); // Unused upper sources read as zero
  assign wake_en_all   = {1'b0, wake_enable_two[6:0], wake_enable_one};

  // Enable and delay registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_enable_one      <= `SPW_WAKE_ENABLE_ONE_RST;
      wake_enable_two      <= `SPW_WAKE_ENABLE_TWO_RST;
      second_delay_setting <= `SPW_SECOND_DELAY_RST;
    end else begin
      if (wr_en1) wake_enable_one <= reg_wdata;
      if (wr_en2) wake_enable_two <= reg_wdata;
      // Codes above 32 s saturate
      if (wr_dly) second_delay_setting <= (reg_wdata > `SPW_DELAY_MAX_CODE) ?
                                          `SPW_DELAY_MAX_CODE : reg_wdata;
    end
  end

  // Wake status: set by any event regardless of enable, write one clears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_status_one <= 8'h00;
      wake_status_two <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        wake_status_one[i] <= w1c(wake_status_one[i], wake_rise_all[i],
                                  wr_st1 & reg_wdata[i]);
        wake_status_two[i] <= w1c(wake_status_two[i], wake_rise_all[i+8],
                                  wr_st2 & reg_wdata[i]);
      end
    end
  end

  // Control bits: soft off is a one-cycle command, restart and stop stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      soft_power_off_cmd <= 1'b0;
      counter_restart    <= 1'b0;
      counter_stop       <= 1'b0;
    end else begin
      soft_power_off_cmd <= wr_ctl & reg_wdata[`SPW_SOFT_OFF_BIT];
      if (wr_ctl) begin
        counter_restart <= reg_wdata[`SPW_RESTART_BIT];
        counter_stop    <= reg_wdata[`SPW_STOP_BIT];
      end
    end
  end

  // Read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_index)
        `SPW_WAKE_ENABLE_ONE:  reg_rdata <= wake_enable_one;
        `SPW_WAKE_ENABLE_TWO:  reg_rdata <= wake_enable_two;
        `SPW_WAKE_STATUS_ONE:  reg_rdata <= wake_status_one;
        `SPW_WAKE_STATUS_TWO:  reg_rdata <= wake_status_two;
        `SPW_SECOND_DELAY:     reg_rdata <= second_delay_setting;
        `SPW_WATCHDOG_CONTROL: reg_rdata <= {1'b0, counter_restart, counter_stop, 5'h00};
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Slow timebase and button timers
  // ****************************************************************
  logic [11:0] slow_div;
  logic        slow_tick;
  logic        btn_slow_a;
  logic        btn_slow;
  logic [15:0] step_count;
  logic        step_tick;
  logic [3:0]  override_steps;
  logic [6:0]  held_steps;
  logic        override_fire;
  logic        button_off_fire;

  // Divide the system clock down to the 32 kHz rate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slow_div  <= 12'h000;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= (slow_div == 12'(SLOW_DIV - 1));
      slow_div  <= (slow_div == 12'(SLOW_DIV - 1)) ? 12'h000 : slow_div + 12'h001;
    end
  end

  // Button resampled into the slow domain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      btn_slow_a <= 1'b0;
      btn_slow   <= 1'b0;
    end else if (slow_tick) begin
      btn_slow_a <= sync_b[WAKE_COUNT];
      btn_slow   <= btn_slow_a;
    end
  end

  // Half second steps counted from the press, restarted on release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      step_count <= 16'h0000;
      step_tick  <= 1'b0;
    end else begin
      step_tick <= 1'b0;
      if (!btn_slow) begin
        step_count <= 16'h0000;
      end else if (slow_tick) begin
        if (step_count == 16'(SLOW_PER_STEP - 1)) begin
          step_count <= 16'h0000;
          step_tick  <= 1'b1;
        end else begin
          step_count <= step_count + 16'h0001;
        end
      end
    end
  end

  // Override and button-off timers count held steps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      override_steps  <= 4'h0;
      held_steps      <= 7'h00;
      override_fire   <= 1'b0;
      button_off_fire <= 1'b0;
    end else begin
      override_fire   <= 1'b0;
      button_off_fire <= 1'b0;
      if (!btn_slow) begin
        override_steps <= 4'h0;
        held_steps     <= 7'h00;
      end else if (step_tick) begin
        if (override_steps != 4'(OVERRIDE_STEPS))
          override_steps <= override_steps + 4'h1;
        if (override_steps == 4'(OVERRIDE_STEPS - 1) && override_enable)
          override_fire <= 1'b1;
        if (held_steps != 7'h7F)
          held_steps <= held_steps + 7'h01;
        if (held_steps == 7'(second_delay_setting) && wake_enable_two[`SPW_OFF_ENABLE_BIT])
          button_off_fire <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Power state flip-flop
  // ****************************************************************
  soft_power_pkg::power_state_type power_state;
  logic                            wake_on;
  logic                            power_clear;

  assign wake_on     = button_fall || |(wake_rise_all & wake_en_all);
  assign power_clear = override_fire || button_off_fire || soft_power_off_cmd;

  // Clear wins over wake; trickle reset restores remembered state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_state <= soft_power_pkg::POWER_OFF;
    end else if (por_rise) begin
      if (trickle_reset_off)
        power_state <= soft_power_pkg::POWER_OFF;
      else if (alarm_remember_enable && alarm_while_absent)
        power_state <= soft_power_pkg::POWER_ON;
      // Otherwise the last valid state is kept
    end else if (power_clear) begin
      power_state <= soft_power_pkg::POWER_OFF;
    end else if (wake_on) begin
      power_state <= soft_power_pkg::POWER_ON;
    end
  end

  // Active-low request to the main supply
  always_ff @(posedge clock or posedge rst) begin
    if (rst) power_on_request_n <= 1'b1;
    else     power_on_request_n <= (power_state != soft_power_pkg::POWER_ON);
  end

  // ****************************************************************
  // ACPI status bits
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      override_status  <= 1'b0;
      button_status    <= 1'b0;
      alarm_sci_status <= 1'b0;
      alarm_pme_status <= 1'b0;
    end else begin
      override_status  <= w1c(override_status, override_fire, override_status_clear);
      button_status    <= override_fire ? 1'b0 :
                          w1c(button_status, button_rise, button_status_clear);
      alarm_sci_status <= w1c(alarm_sci_status, alarm_rise, alarm_sci_status_clear);
      alarm_pme_status <= w1c(alarm_pme_status, alarm_rise, alarm_pme_status_clear);
    end
  end

  // ****************************************************************
  // Event routing
  // ****************************************************************
  logic pm_event;
  logic pme_event;
  logic sci_event;
  logic smi_event;
  logic sci_level;
  soft_power_pkg::sci_route_type route;

  assign route     = soft_power_pkg::sci_route_type'(sci_route_select);
  assign pm_event  = (button_status & button_enable) | (alarm_sci_status & alarm_sci_enable);
  assign pme_event = (alarm_pme_status & alarm_pme_enable) |
                     (device_interrupt_pme_enable & smi_to_pme_enable & smi_event_any);
  assign sci_event = sci_route_enable & (pm_event | (gpe_sci_enable & pme_event) |
                     (device_interrupt_pme_enable & smi_to_pme_enable & smi_event_any));
  assign smi_event = smi_route_enable & (pm_event | smi_event_any);
  assign sci_level = sci_active_high ? sci_event : ~sci_event;

  // Registered interrupt and pin outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      smi_out         <= 1'b0;
      irq11_out       <= 1'b0;
      serirq_sci      <= 1'b0;
      pme_sci_pin_out <= 1'b0;
      pme_sci_pin_oe  <= 1'b0;
    end else begin
      smi_out    <= smi_event;
      irq11_out  <= (route == soft_power_pkg::SCI_TO_IRQ11) && sci_event;
      serirq_sci <= (route == soft_power_pkg::SCI_TO_SERIRQ) && sci_event && !trickle_only;
      if (route == soft_power_pkg::SCI_TO_PME_PIN) begin
        // Shared pin carries the SCI, open drain unless push-pull
        pme_sci_pin_out <= sci_level;
        pme_sci_pin_oe  <= sci_push_pull | ~sci_level;
      end else begin
        pme_sci_pin_out <= 1'b0;
        pme_sci_pin_oe  <= pme_event;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_override_off_request: assert property (@(posedge clock) disable iff (rst)
    override_fire |-> ##2 power_on_request_n)
    else $error("override did not drop power request");

  a_override_needs_enable: assert property (@(posedge clock) disable iff (rst)
    override_fire |-> $past(override_enable))
    else $error("override fired while disabled");

  a_override_sets_status: assert property (@(posedge clock) disable iff (rst)
    override_fire |=> override_status && !button_status)
    else $error("override status handling wrong");

  a_override_status_sticky: assert property (@(posedge clock) disable iff (rst)
    override_status && !override_status_clear |=> override_status)
    else $error("override status lost without clear");

  a_timer_release_clears: assert property (@(posedge clock) disable iff (rst)
    !btn_slow |=> override_steps == 4'h0 && step_count == 16'h0000)
    else $error("override timer not cleared on release");

  a_soft_off_cmd: assert property (@(posedge clock) disable iff (rst)
    wr_ctl && reg_wdata[7] && !por_rise |=> ##2 power_on_request_n)
    else $error("soft off did not drop power request");

  a_trickle_off: assert property (@(posedge clock) disable iff (rst)
    por_rise && trickle_reset_off |=> ##1 power_on_request_n)
    else $error("trickle reset off not honoured");

  a_alarm_pme_status: assert property (@(posedge clock) disable iff (rst)
    alarm_rise |=> alarm_pme_status)
    else $error("alarm did not set pme status");

  a_smi_route: assert property (@(posedge clock) disable iff (rst)
    !smi_route_enable |=> !smi_out)
    else $error("smi raised while unrouted");

  a_serirq_trickle: assert property (@(posedge clock) disable iff (rst)
    trickle_only |=> !serirq_sci)
    else $error("serial irq driven on trickle power");

endmodule

/* verification/supply_model.sv */
`timescale 1ns/1ns
// ****************************************
// Main supply and shared pin model
// ****************************************
module supply_model (
  input  wire logic clock,
  input  wire logic power_on_request_n,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      supply_on,
  output wire logic pme_pin
);
  // Supply follows its active low request one cycle later
  always_ff @(posedge clock) begin
    supply_on <= !power_on_request_n;
  end
  // Pull-up holds the shared pin high while nobody drives it
  assign pme_pin = pin_oe ? pin_out : 1'h1;
endmodule

/* verification/tb_soft_power_acpi_events.sv */
`timescale 1ns/1ns
`include "soft_power_consts.svh"
// ****************************************
// Bench for soft power and event routing
// ****************************************
module tb_soft_power_acpi_events;
  localparam int STEP = 3814; // Cycles per half second step, one slow tick per step
  logic clock = '0;
  logic rst = '1;
  logic trickle_por = '0, trickle_only = '0, button_in = '0, alarm_event = '0;
  logic alarm_while_absent = '0, alarm_remember_enable = '0, trickle_reset_off = '0;
  logic [14:0] wake_events = '0;
  logic [7:0] reg_index = '0, reg_wdata = '0;
  logic reg_write = '0, sci_route_enable = '0, smi_route_enable = '0, override_enable = '0;
  logic override_status_clear = '0, button_enable = '0, button_status_clear = '0;
  logic alarm_sci_enable = '0, alarm_sci_status_clear = '0, alarm_pme_enable = '0;
  logic alarm_pme_status_clear = '0, gpe_sci_enable = '0, device_interrupt_pme_enable = '0;
  logic smi_to_pme_enable = '0, smi_event_any = '0, sci_active_high = '0, sci_push_pull = '0;
  logic [1:0] sci_route_select = '0;
  logic [7:0] reg_rdata;
  logic power_on_request_n, override_status, button_status, alarm_sci_status;
  logic alarm_pme_status, smi_out, irq11_out, serirq_sci, pme_sci_pin_out, pme_sci_pin_oe;
  logic supply_on;
  wire  pme_pin;
  int   mismatches = 0;
  int   n_compared = 0;

  soft_power_acpi_events #(.SLOW_PER_STEP(1)) i_dut (.clock, .rst, .trickle_por, .trickle_only,
    .button_in, .wake_events, .alarm_event, .alarm_while_absent, .alarm_remember_enable,
    .trickle_reset_off, .reg_index, .reg_write, .reg_wdata, .sci_route_enable, .smi_route_enable,
    .override_enable, .override_status_clear, .button_enable, .button_status_clear,
    .alarm_sci_enable, .alarm_sci_status_clear, .alarm_pme_enable, .alarm_pme_status_clear,
    .gpe_sci_enable, .device_interrupt_pme_enable, .smi_to_pme_enable, .smi_event_any,
    .sci_route_select, .sci_active_high, .sci_push_pull, .reg_rdata, .power_on_request_n,
    .override_status, .button_status, .alarm_sci_status, .alarm_pme_status, .smi_out,
    .irq11_out, .serirq_sci, .pme_sci_pin_out, .pme_sci_pin_oe);
  supply_model i_supply (.clock, .power_on_request_n, .pin_out(pme_sci_pin_out),
    .pin_oe(pme_sci_pin_oe), .supply_on, .pme_pin);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock);
    reg_index <= idx;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clock);
    reg_index <= idx;
    repeat (2) @(posedge clock);
    #1 chk(reg_rdata, exp, "register read");
  endtask
  task automatic wait_power(input logic exp_n, input int limit);
    for (int i = 0; i < limit && power_on_request_n !== exp_n; i++) @(posedge clock);
    #1 chk(power_on_request_n, exp_n, "power request");
  endtask
  // Pulse selector: 0 wake 0, 1 button clear, 2 override clear, 3 alarm, 4 pme clear, 5 por
  task automatic set_pulse(input int k, input logic v);
    case (k)
      0:       wake_events[0] <= v;
      1:       button_status_clear <= v;
      2:       override_status_clear <= v;
      3:       alarm_event <= v;
      4:       alarm_pme_status_clear <= v;
      default: trickle_por <= v;
    endcase
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    set_pulse(k, 1'h1);
    @(posedge clock);
    set_pulse(k, 1'h0);
  endtask
  task automatic hold_button(input int n);
    @(posedge clock);
    button_in <= 1'h1;
    repeat (n) @(posedge clock);
    button_in <= 1'h0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_regs;
    chk(power_on_request_n, 8'h01, "request after reset");
    rd(`SPW_WAKE_ENABLE_ONE, 8'h00);
    rd(`SPW_WAKE_ENABLE_TWO, 8'h80);
    rd(`SPW_SECOND_DELAY, 8'h00);
    rd(8'h55, 8'h00);
    wr(`SPW_SECOND_DELAY, 8'hFF);
    rd(`SPW_SECOND_DELAY, 8'h3F);
    wr(`SPW_SECOND_DELAY, 8'h00);
  endtask
  task automatic t_wake;
    pulse(0);
    rd(`SPW_WAKE_STATUS_ONE, 8'h01);
    chk(power_on_request_n, 8'h01, "disabled wake");
    wr(`SPW_WAKE_STATUS_ONE, 8'h01);
    rd(`SPW_WAKE_STATUS_ONE, 8'h00);
    wr(`SPW_WAKE_ENABLE_ONE, 8'h01);
    pulse(0);
    wait_power(1'h0, 20);
  endtask
  task automatic t_soft_off;
    wr(`SPW_WATCHDOG_CONTROL, 8'h80);
    wait_power(1'h1, 10);
    rd(`SPW_WATCHDOG_CONTROL, 8'h00);
    wr(`SPW_WATCHDOG_CONTROL, 8'h60);
    rd(`SPW_WATCHDOG_CONTROL, 8'h60);
    wr(`SPW_WATCHDOG_CONTROL, 8'h00);
  endtask
  task automatic t_button;
    hold_button(20);
    wait_power(1'h0, 20);
    chk(button_status, 8'h01, "button status");
    pulse(1);
    hold_button(3 * STEP);
    chk(power_on_request_n, 8'h01, "button off");
    chk(override_status, 8'h00, "no override");
    wait_power(1'h0, 20);
    wr(`SPW_WAKE_ENABLE_TWO, 8'h00);
    // Let the slow domain see the release so the timers restart
    repeat (2 * STEP + 8) @(posedge clock);
    hold_button(9 * STEP);
    chk(power_on_request_n, 8'h00, "override disabled");
    chk(override_status, 8'h00, "override disabled");
  endtask
  task automatic t_override;
    // Release must reach the slow domain before the next press
    repeat (2 * STEP + 8) @(posedge clock);
    override_enable <= 1'h1;
    button_in <= 1'h1;
    repeat (8 * STEP - 20) @(posedge clock);
    chk(power_on_request_n, 8'h00, "override too early");
    wait_power(1'h1, 3 * STEP);
    chk(override_status, 8'h01, "override status");
    chk(button_status, 8'h00, "button status");
    button_in <= 1'h0;
    wait_power(1'h0, 20);
    chk(override_status, 8'h01, "status kept");
    pulse(2);
    repeat (3) @(posedge clock);
    chk(override_status, 8'h00, "status cleared");
  endtask
  task automatic t_routes;
    sci_route_select <= 2'h1;
    alarm_pme_enable <= 1'h1;
    gpe_sci_enable <= 1'h1;
    sci_route_enable <= 1'h1;
    pulse(3);
    repeat (8) @(posedge clock);
    chk(alarm_pme_status, 8'h01, "alarm pme status");
    chk(pme_pin, 8'h00, "pme pin");
    chk(irq11_out, 8'h01, "sci on irq11");
    smi_route_enable <= 1'h1;
    smi_event_any <= 1'h1;
    pulse(4);
    repeat (8) @(posedge clock);
    chk(smi_out, 8'h01, "smi route");
    chk(alarm_pme_status, 8'h00, "alarm cleared");
    chk(pme_pin, 8'h01, "pme released");
    chk(alarm_sci_status, 8'h01, "alarm sci status");
    sci_route_select <= 2'h0;
    device_interrupt_pme_enable <= 1'h1;
    smi_to_pme_enable <= 1'h1;
    repeat (4) @(posedge clock);
    chk(pme_pin, 8'h00, "sci on shared pin");
    chk(pme_sci_pin_oe, 8'h01, "open drain drives low");
    sci_route_select <= 2'h2;
    repeat (4) @(posedge clock);
    chk(serirq_sci, 8'h01, "sci on serial irq");
    trickle_only <= 1'h1;
    repeat (4) @(posedge clock);
    chk(serirq_sci, 8'h00, "serial irq on trickle");
    trickle_only <= 1'h0;
  endtask
  task automatic t_trickle;
    trickle_reset_off <= 1'h1;
    pulse(5);
    wait_power(1'h1, 20);
    trickle_reset_off <= 1'h0;
    alarm_remember_enable <= 1'h1;
    alarm_while_absent <= 1'h1;
    pulse(5);
    wait_power(1'h0, 20);
    repeat (2) @(posedge clock);
    chk(supply_on, 8'h01, "supply on");
  endtask

  // ****************************************
  // Verdict
  // ****************************************
  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Clock at 125 MHz
  initial begin
    forever #4 clock = ~clock;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    t_reset_regs();
    t_wake();
    t_soft_off();
    t_button();
    t_override();
    t_routes();
    t_trickle();
    report_and_stop();
  end
  // Watchdog cuts a hang short
  initial begin
    #(8 * 120000);
    mismatches++;
    report_and_stop();
  end
endmodule
